// [hdl/thermal_params_pkg.sv]
// Constants, field layouts and carrier types for the thermal throttle parameter bank.
// Assumes one clock domain shared with the configuration port and the throttle neighbours.
package thermal_params_pkg;

  // Dword offsets
  localparam logic [7:0] OFF_SAFE_FALLBACK = 8'h64;
  localparam logic [7:0] OFF_RANK_COOLING  = 8'h80;
  localparam logic [7:0] OFF_CLOSED_LOOP   = 8'h84;

  // Fallback parameter fields
  localparam int WIN_LSB      = 26;
  localparam int WIN_W        = 6;
  localparam int FDUTY_LSB    = 16;
  localparam int DUTY_W       = 10;
  localparam int FCOEF_LSB    = 8;
  localparam int COEF_W       = 8;
  localparam int ENERGY_LSB   = 0;
  localparam int ENERGY_W     = 8;

  // Closed-loop fields
  localparam int MINRUN_LSB   = 8;
  localparam int DBLREF_BIT   = 4;
  localparam int STALL_LSB    = 0;
  localparam int RANKS        = 4;

  // Throttle mode that selects direct control
  localparam logic [1:0] MODE_DIRECT = 2'h2;

  // Reset values and closed-loop write mask
  localparam logic [31:0] RST_SAFE_FALLBACK = 32'h04FF_0100;
  localparam logic [31:0] RST_RANK_COOLING  = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_CLOSED_LOOP   = 32'h0000_4000;
  localparam logic [31:0] CLOSED_LOOP_MASK  = 32'h0003_FF1F;
  localparam logic [WIN_W:0] CNT_RST        = 7'h00;

  // Configuration dword request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } cfg_req_s;

endpackage

// [hdl/dram_thermal_throttle_params.sv]
// Per-channel thermal throttle parameter bank with safe-value fallback.
// Assumes config requests, ZQ tick, mode, apply-safe and capability inputs share CLK_IN.
// What this block does
// [R1] Use fallback values once ZQ count exceeds window
// [R2] Any coefficient or closed-loop write restarts count
// [R3] Reload stalled-cycle count when window is exceeded
// [R4] Software never programs window length as zero
// [R5] Fallback duty, reset 255, replaces minimum run
// [R6] Fallback heat removal, reset 1, replaces coefficients
// [R7] Hold activate energy weight, reset zero
// [R8] Four per-rank cooling coefficients, each reset 255
// [R9] Share rank state beyond four ranks
// [R10] Software scales coefficients, assumes doubled refresh
// [R11] Minimum run clocks field, ten bits, reset 64
// [R12] Lockstep software keeps minimum run field stable
// [R13] Double refresh force acts only in mode 2
// [R14] Double refresh force settable only if capable
// [R15] Rank stall vector forces stall in mode 2
// [R16] Two-bit mode selects throttle source
// [R17] Fallback applies only while apply-safe is set
// [R18] Count ZQ intervals, saturating above window
`timescale 1ns/1ns
module dram_thermal_throttle_params
  import thermal_params_pkg::*;
(
  // Clock and reset
  input  wire logic                 CLK_IN,
  input  wire logic                 ARST_N_IN,
  // Configuration dword port
  input  wire cfg_req_s             CFG_REQ_IN,
  output logic [31:0]               CFG_RDATA_OUT,
  output logic                      CFG_RVALID_OUT,
  // Controls from neighbouring throttle logic
  input  wire logic [1:0]           THROTTLE_MODE_IN,
  input  wire logic                 APPLY_SAFE_IN,
  input  wire logic                 ZQ_TICK_IN,
  input  wire logic                 SELF_REFRESH_CAPABLE_IN,
  input  wire logic                 RANKS_OVER_FOUR_IN,
  // Effective parameters
  output logic [RANKS*COEF_W-1:0]   COOL_COEF_OUT,
  output logic [DUTY_W-1:0]         MIN_RUN_CLOCKS_OUT,
  output logic [ENERGY_W-1:0]       ACT_ENERGY_OUT,
  output logic [RANKS-1:0]          RANK_STALL_OUT,
  output logic                      DOUBLE_REFRESH_OUT,
  output logic                      STALL_COUNT_RELOAD_OUT,
  output logic                      FALLBACK_ACTIVE_OUT,
  output logic                      RANK_STATE_SHARED_OUT
);

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
    hit = (addr == off);
  endfunction

  logic [31:0]             fallback_reg;
  logic [31:0]             cooling_reg;
  logic [31:0]             closed_reg;
  logic [WIN_W:0]          zq_count_reg;
  logic [31:0]             rdata_reg;
  logic                    rvalid_reg;
  logic [RANKS*COEF_W-1:0] coef_out_reg;
  logic [DUTY_W-1:0]       minrun_out_reg;
  logic [ENERGY_W-1:0]     energy_out_reg;
  logic [RANKS-1:0]        stall_out_reg;
  logic                    dblref_out_reg;
  logic                    reload_reg;
  logic                    fallback_out_reg;
  logic                    shared_reg;

  logic [31:0]             fallback_next;
  logic [31:0]             cooling_next;
  logic [31:0]             closed_next;
  logic [WIN_W:0]          zq_count_next;
  logic [31:0]             rdata_next;
  logic [RANKS*COEF_W-1:0] coef_next;
  logic [DUTY_W-1:0]       minrun_next;
  logic [RANKS-1:0]        stall_next;
  logic                    dblref_next;
  logic                    reload_next;
  logic                    fallback_next_act;

  // Address decode
  wire logic wr_fallback = CFG_REQ_IN.wr && hit(CFG_REQ_IN.addr, OFF_SAFE_FALLBACK);
  wire logic wr_cooling  = CFG_REQ_IN.wr && hit(CFG_REQ_IN.addr, OFF_RANK_COOLING);
  wire logic wr_closed   = CFG_REQ_IN.wr && hit(CFG_REQ_IN.addr, OFF_CLOSED_LOOP);
  wire logic restart     = wr_cooling || wr_closed; // [R2]

  // Field views
  wire logic [WIN_W-1:0]    window   = fallback_reg[WIN_LSB +: WIN_W];
  wire logic [DUTY_W-1:0]   f_duty   = fallback_reg[FDUTY_LSB +: DUTY_W];
  wire logic [COEF_W-1:0]   f_coef   = fallback_reg[FCOEF_LSB +: COEF_W];
  wire logic [DUTY_W-1:0]   min_run  = closed_reg[MINRUN_LSB +: DUTY_W];
  wire logic [RANKS-1:0]    stall_v  = closed_reg[STALL_LSB +: RANKS];
  wire logic                direct   = (THROTTLE_MODE_IN == MODE_DIRECT); // [R16]

  // Fallback register: plain store; a zero window is left to software [R4]
  assign fallback_next = wr_fallback ? CFG_REQ_IN.wdata : fallback_reg; // [R5] [R6] [R7]
  assign cooling_next  = wr_cooling ? CFG_REQ_IN.wdata : cooling_reg; // [R8]

  // Closed-loop register; double refresh force can only be set when capable
  wire logic [31:0] closed_wmask = CFG_REQ_IN.wdata & CLOSED_LOOP_MASK;
  wire logic        dblref_wbit  = CFG_REQ_IN.wdata[DBLREF_BIT] && SELF_REFRESH_CAPABLE_IN; // [R14]
  assign closed_next = wr_closed ?
    {closed_wmask[31:DBLREF_BIT+1], dblref_wbit, closed_wmask[DBLREF_BIT-1:0]} : closed_reg; // [R11]

  // ZQ interval counter, saturating one above the window
  wire logic [WIN_W:0] win_ext   = {1'b0, window};
  wire logic           exceeded  = (zq_count_reg > win_ext); // [R1]
  wire logic [WIN_W:0] count_inc = zq_count_reg + 7'h01;
  assign zq_count_next = restart ? CNT_RST :
                         (ZQ_TICK_IN && !exceeded) ? count_inc : zq_count_reg; // [R18] [R2]
  assign reload_next   = !restart && ZQ_TICK_IN && !exceeded && (count_inc > win_ext); // [R3]

  // Substitution while window exceeded and apply-safe enabled
  assign fallback_next_act = exceeded && APPLY_SAFE_IN; // [R17] [R1]
  assign minrun_next = fallback_next_act ? f_duty : min_run; // [R5]

  // Per-rank coefficients; rank 0 serves all ranks when state is shared
  genvar r;
  generate
    for (r = 0; r < RANKS; r = r + 1)
    begin : g_rank
      wire logic [COEF_W-1:0] own = RANKS_OVER_FOUR_IN ? cooling_reg[COEF_W-1:0] :
                                                        cooling_reg[r*COEF_W +: COEF_W]; // [R9]
      assign coef_next[r*COEF_W +: COEF_W] = fallback_next_act ? f_coef : own; // [R6]
      assign stall_next[r] = direct && (RANKS_OVER_FOUR_IN ? (|stall_v) : stall_v[r]); // [R15] [R9]
    end
  endgenerate

  assign dblref_next = direct && closed_reg[DBLREF_BIT]; // [R13]

  // Read decode, unmapped offsets read zero
  assign rdata_next = !CFG_REQ_IN.rd ? 32'h0000_0000 :
                      hit(CFG_REQ_IN.addr, OFF_SAFE_FALLBACK) ? fallback_reg :
                      hit(CFG_REQ_IN.addr, OFF_RANK_COOLING)  ? cooling_reg :
                      hit(CFG_REQ_IN.addr, OFF_CLOSED_LOOP)   ? closed_reg : 32'h0000_0000;

  // Register storage
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      fallback_reg <= RST_SAFE_FALLBACK;
    end
    else
    begin
      fallback_reg <= fallback_next;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      cooling_reg <= RST_RANK_COOLING;
    end
    else
    begin
      cooling_reg <= cooling_next;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      closed_reg <= RST_CLOSED_LOOP;
    end
    else
    begin
      closed_reg <= closed_next;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      zq_count_reg <= CNT_RST;
    end
    else
    begin
      zq_count_reg <= zq_count_next; // [R18]
    end
  end

  // Read response
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rvalid_reg <= CFG_REQ_IN.rd;
    end
  end

  // Effective parameter outputs
  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      coef_out_reg <= RST_RANK_COOLING;
    end
    else
    begin
      coef_out_reg <= coef_next; // [R6] [R8]
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      minrun_out_reg <= RST_CLOSED_LOOP[MINRUN_LSB +: DUTY_W];
    end
    else
    begin
      minrun_out_reg <= minrun_next; // [R5] [R11]
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      energy_out_reg <= RST_SAFE_FALLBACK[ENERGY_LSB +: ENERGY_W];
    end
    else
    begin
      energy_out_reg <= fallback_reg[ENERGY_LSB +: ENERGY_W]; // [R7]
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      stall_out_reg <= '0;
    end
    else
    begin
      stall_out_reg <= stall_next; // [R15]
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      dblref_out_reg <= 1'b0;
    end
    else
    begin
      dblref_out_reg <= dblref_next; // [R13]
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      reload_reg <= 1'b0;
    end
    else
    begin
      reload_reg <= reload_next; // [R3]
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      fallback_out_reg <= 1'b0;
    end
    else
    begin
      fallback_out_reg <= fallback_next_act; // [R1]
    end
  end

  always_ff @(posedge CLK_IN or negedge ARST_N_IN)
  begin
    if (!ARST_N_IN)
    begin
      shared_reg <= 1'b0;
    end
    else
    begin
      shared_reg <= RANKS_OVER_FOUR_IN; // [R9]
    end
  end

  assign CFG_RDATA_OUT          = rdata_reg;
  assign CFG_RVALID_OUT         = rvalid_reg;
  assign COOL_COEF_OUT          = coef_out_reg;
  assign MIN_RUN_CLOCKS_OUT     = minrun_out_reg;
  assign ACT_ENERGY_OUT         = energy_out_reg;
  assign RANK_STALL_OUT         = stall_out_reg;
  assign DOUBLE_REFRESH_OUT     = dblref_out_reg;
  assign STALL_COUNT_RELOAD_OUT = reload_reg;
  assign FALLBACK_ACTIVE_OUT    = fallback_out_reg;
  assign RANK_STATE_SHARED_OUT  = shared_reg;

endmodule

// [sim/thermal_params_monitor.sv]
// Concurrent checks on the thermal parameter bank ports.
// Assumes a bind from the bench top file and one clock domain.
`timescale 1ns/1ns
module thermal_params_monitor
  import thermal_params_pkg::*;
(
  input wire logic                       CLK_IN, ARST_N_IN, APPLY_SAFE_IN, RANKS_OVER_FOUR_IN, CFG_RVALID_OUT,
  input wire cfg_req_s                   CFG_REQ_IN,
  input wire logic [1:0]                 THROTTLE_MODE_IN,
  input wire logic [RANKS-1:0]           RANK_STALL_OUT,
  input wire logic                       DOUBLE_REFRESH_OUT, STALL_COUNT_RELOAD_OUT,
  input wire logic                       FALLBACK_ACTIVE_OUT, RANK_STATE_SHARED_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire coef_wr = CFG_REQ_IN.wr && (CFG_REQ_IN.addr == OFF_RANK_COOLING || CFG_REQ_IN.addr == OFF_CLOSED_LOOP);
  sequence shared_two;
    RANKS_OVER_FOUR_IN ##1 RANKS_OVER_FOUR_IN;
  endsequence
  AST_READ_ANSWER: assert property (CFG_REQ_IN.rd |=> CFG_RVALID_OUT) else $error("read not answered");
  AST_STALL_MODE: assert property (THROTTLE_MODE_IN != MODE_DIRECT |=> RANK_STALL_OUT == '0)
    else $error("stall outside direct mode");
  AST_DBLREF_MODE: assert property (THROTTLE_MODE_IN != MODE_DIRECT |=> !DOUBLE_REFRESH_OUT)
    else $error("double refresh outside direct mode");
  AST_SAFE_OFF: assert property (!APPLY_SAFE_IN |=> !FALLBACK_ACTIVE_OUT) else $error("fallback while off");
  AST_SAFE_RISE: assert property ($rose(FALLBACK_ACTIVE_OUT) |-> $past(APPLY_SAFE_IN)) else $error("bad rise");
  AST_RESTART: assert property (coef_wr |-> ##2 !FALLBACK_ACTIVE_OUT) else $error("write kept fallback");
  AST_RELOAD_ONCE: assert property (STALL_COUNT_RELOAD_OUT |=> !STALL_COUNT_RELOAD_OUT) else $error("long reload");
  AST_SHARED_FLAG: assert property (RANKS_OVER_FOUR_IN |=> RANK_STATE_SHARED_OUT) else $error("shared flag");
  AST_SHARED_STALL: assert property (shared_two |=> (&RANK_STALL_OUT || RANK_STALL_OUT == '0))
    else $error("shared stall bits differ");
endmodule

// [sim/tb.sv]
// Self-checking bench for the thermal parameter bank.
// Assumes the package, design and monitor are compiled first.
`timescale 1ns/1ns
module tb
  import thermal_params_pkg::*;
;
  logic CLK_IN = 0, ARST_N_IN = 0, APPLY_SAFE_IN = 1, ZQ_TICK_IN = 0, SELF_REFRESH_CAPABLE_IN = 0;
  logic RANKS_OVER_FOUR_IN = 0, CFG_RVALID_OUT, DOUBLE_REFRESH_OUT, STALL_COUNT_RELOAD_OUT;
  logic FALLBACK_ACTIVE_OUT, RANK_STATE_SHARED_OUT;
  logic [1:0] THROTTLE_MODE_IN = 0;
  cfg_req_s CFG_REQ_IN = '0;
  logic [31:0] CFG_RDATA_OUT, COOL_COEF_OUT, seed = 32'hBA8C, v, p, c, cl;
  logic [9:0] MIN_RUN_CLOCKS_OUT;
  logic [7:0] ACT_ENERGY_OUT;
  logic [3:0] RANK_STALL_OUT;
  logic [31:0] exp_q[$];
  int failures = 0, checks = 0, cyc = 0, reloads = 0;
  always #50 CLK_IN = ~CLK_IN;
  dram_thermal_throttle_params dram_thermal_throttle_params_inst (.*);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic req(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(negedge CLK_IN);
    CFG_REQ_IN = '{w, !w, a, d};
    if (!w) exp_q.push_back(d);
    @(negedge CLK_IN);
    CFG_REQ_IN = '0;
  endtask
  task automatic tick();
    @(negedge CLK_IN);
    ZQ_TICK_IN = 1;
    @(negedge CLK_IN);
    ZQ_TICK_IN = 0;
  endtask
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Read results against the oldest note
  always @(negedge CLK_IN)
    if (CFG_RVALID_OUT === 1'b1)
      chk(CFG_RDATA_OUT, exp_q.size() > 0 ? exp_q.pop_front() : 'x);
  // Reload pulses seen on the stall-count output
  always @(negedge CLK_IN)
    if (STALL_COUNT_RELOAD_OUT === 1'b1)
      reloads++;
  always @(posedge CLK_IN)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      failures++;
      report_and_stop();
    end
  end
  initial
  begin
    repeat (10) @(negedge CLK_IN);
    ARST_N_IN = 1;
    req(0, OFF_SAFE_FALLBACK, RST_SAFE_FALLBACK);
    req(0, OFF_RANK_COOLING, RST_RANK_COOLING);
    req(0, OFF_CLOSED_LOOP, RST_CLOSED_LOOP);
    req(0, 8'h88, 32'h0);
    for (int m = 0; m < 4; m++)
    begin
      THROTTLE_MODE_IN = 2'h0;
      SELF_REFRESH_CAPABLE_IN = (m != 0);
      v = xs() | 32'h10;
      req(1, OFF_CLOSED_LOOP, v);
      THROTTLE_MODE_IN = m[1:0];
      cl = v & CLOSED_LOOP_MASK & ((m != 0) ? 32'hFFFFFFFF : 32'hFFFFFFEF);
      req(0, OFF_CLOSED_LOOP, cl);
      chk(RANK_STALL_OUT, m == 2 ? cl[3:0] : 4'h0);
      chk(DOUBLE_REFRESH_OUT, m == 2 ? cl[4] : 1'b0);
      chk(MIN_RUN_CLOCKS_OUT, cl[17:8]);
    end
    v = xs();
    p = {6'h02, v[25:0]};
    req(1, OFF_SAFE_FALLBACK, p);
    c = xs();
    req(1, OFF_RANK_COOLING, c);
    repeat (2) tick();
    chk(FALLBACK_ACTIVE_OUT, 1'b0);
    chk(reloads, 0);
    tick();
    repeat (4) @(negedge CLK_IN);
    chk(reloads, 1);
    chk(FALLBACK_ACTIVE_OUT, 1'b1);
    chk(COOL_COEF_OUT, {4{p[15:8]}});
    chk(MIN_RUN_CLOCKS_OUT, p[25:16]);
    chk(ACT_ENERGY_OUT, p[7:0]);
    APPLY_SAFE_IN = 0;
    repeat (2) @(negedge CLK_IN);
    chk(COOL_COEF_OUT, c);
    APPLY_SAFE_IN = 1;
    repeat (2) @(negedge CLK_IN);
    chk(FALLBACK_ACTIVE_OUT, 1'b1);
    req(1, OFF_RANK_COOLING, c);
    @(negedge CLK_IN);
    chk(COOL_COEF_OUT, c);
    THROTTLE_MODE_IN = MODE_DIRECT;
    RANKS_OVER_FOUR_IN = 1;
    repeat (2) @(negedge CLK_IN);
    chk(COOL_COEF_OUT, {4{c[7:0]}});
    chk(RANK_STALL_OUT, |cl[3:0] ? 4'hF : 4'h0);
    report_and_stop();
  end
endmodule
bind dram_thermal_throttle_params thermal_params_monitor thermal_params_monitor_inst (.*);
